/* File: rtl/multi_step_speed_sequencer.v */
`timescale 1ns/1ps
`include "seq_defs.vh"
module multi_step_speed_sequencer #(
   parameter TICK_CYCLES = `SEQ_TICK_NS / `SEQ_CLK_NS,
   parameter TW          = 16,
   parameter FW          = 16
) (
   input  wire          mclk,
   input  wire          sys_rst,
   input  wire [7:0]    s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [7:0]    s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   input  wire          forwardRunTerm,
   input  wire          reverseRunTerm,
   input  wire          resetCmdTerm,
   input  wire          freqSrcSelTerm,
   input  wire          keyFwd,
   input  wire          keyRev,
   input  wire          keyStop,
   input  wire          keyReset,
   input  wire          protTrip,
   output reg           runCmd_q,
   output reg           dirRev_q,
   output reg  [1:0]    rampSet_q,
   output reg  [FW-1:0] freqRef_q,
   output reg  [2:0]    stageOut_q,
   output reg           decelStop_q,
   output reg           irq_q
);
   localparam ST_IDLE = 3'h0;
   localparam ST_RUN  = 3'h1;
   localparam ST_SUSP = 3'h2;
   localparam ST_TRIP = 3'h3;
   localparam ST_DONE = 3'h4;
   localparam [2:0] LAST = `SEQ_LAST;

   reg  [2:0]           state_q;
   reg  [2:0]           stage_q;
   reg  [TW-1:0]        remain_q;
   reg                  load_q;
   reg                  armed_q;
   reg  [2:0]           ctrl_q;
   reg  [10:0]          rstCode_q;
   reg  [`IRQ_W-1:0]    intStat_q;
   reg  [`IRQ_W-1:0]    intMask_q;
   reg  [`IRQ_W-1:0]    ev_q;
   reg                  rstActPrev_q;
   reg                  selPrev_q;
   reg                  awHeld_q;
   reg                  wHeld_q;
   reg  [7:0]           awAddr_q;
   reg  [31:0]          wData_q;
   reg  [3:0]           wStrb_q;
   reg  [31:0]          rdMux;
   reg                  rdOk;

   wire                 tick;
   wire [TW-1:0]        curTime;
   wire [FW-1:0]        curFreq;
   wire [7:0]           curDir;
   wire [TW-1:0]        busTime;
   wire [FW-1:0]        busFreq;
   wire [7:0]           busDir;

   // Write decode
   wire        wrGo   = awHeld_q & wHeld_q & ~s_axi_bvalid;
   wire [2:0]  wIdx   = awAddr_q[4:2];
   wire        wTblOk = (awAddr_q[1:0] == 2'h0) && (wIdx < `SEQ_STAGES);
   wire        wrTime = wrGo & wTblOk & (awAddr_q[7:5] == `R_TIME);
   wire        wrFreq = wrGo & wTblOk & (awAddr_q[7:5] == `R_FREQ);
   wire        wrDir  = wrGo & wTblOk & (awAddr_q[7:5] == `R_DIR);
   wire        wrOwn  = (awAddr_q == `A_CTRL) | (awAddr_q == `A_RSTC) |
                        (awAddr_q == `A_STAT) | (awAddr_q == `A_INTS) |
                        (awAddr_q == `A_INTM);
   wire [31:0] wMask  = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                         {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
   wire [31:0] ctrlW  = ({29'h0, ctrl_q} & ~wMask) | (wData_q & wMask);
   wire [31:0] rstcW  = ({21'h0, rstCode_q} & ~wMask) | (wData_q & wMask);
   wire [31:0] intmW  = ({28'h0, intMask_q} & ~wMask) | (wData_q & wMask);

   wire        rdGo   = s_axi_arvalid & s_axi_arready;
   // Run source and start/stop events
   wire [1:0]  runSrc  = ctrl_q[`CTRL_SRC_LO+1:`CTRL_SRC_LO];
   wire        srcTerm = (runSrc == `SRC_TERM);
   wire        termRun = forwardRunTerm | reverseRunTerm;
   wire        startEv = srcTerm ? termRun :
                         (runSrc == `SRC_KFWD) ? keyFwd :
                         (runSrc == `SRC_KREV) ? keyRev : 1'b0;
   wire        stopEv  = srcTerm ? ~termRun : keyStop;

   // Reset terminal polarity and edge
   wire        rstAct  = (rstCode_q == `RSTC_ON)  ?
                         resetCmdTerm & ~rstActPrev_q :
                         (rstCode_q == `RSTC_OFF) ?
                         ~resetCmdTerm & rstActPrev_q : 1'b0;
   wire        rstEv   = keyReset | rstAct;
   wire        selTog  = freqSrcSelTerm ^ selPrev_q;

   // Stage direction code decode
   wire        isRev = (curDir >= `DIR_REV1) && (curDir <= `DIR_REV4);
   wire        isFwd = (curDir >= `DIR_FWD1) && (curDir <= `DIR_FWD4);
   wire [7:0]  dirOff = isRev ? curDir - `DIR_REV1 :
                        isFwd ? curDir - `DIR_FWD1 : 8'h00;

   tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
      .mclk(mclk), .sys_rst(sys_rst), .enable(state_q == ST_RUN),
      .tick_q(tick));

   stage_store #(.N(`SEQ_STAGES), .W(TW), .RST(`TIME_RST)) u_time (
      .mclk(mclk), .sys_rst(sys_rst), .wrEn(wrTime), .wrIdx(wIdx),
      .wrData(wData_q[TW-1:0]), .wrMask(wMask[TW-1:0]), .seqIdx(stage_q),
      .seqData(curTime), .busIdx(s_axi_araddr[4:2]), .busData(busTime));

   stage_store #(.N(`SEQ_STAGES), .W(FW), .RST(`FREQ_RST)) u_freq (
      .mclk(mclk), .sys_rst(sys_rst), .wrEn(wrFreq), .wrIdx(wIdx),
      .wrData(wData_q[FW-1:0]), .wrMask(wMask[FW-1:0]), .seqIdx(stage_q),
      .seqData(curFreq), .busIdx(s_axi_araddr[4:2]), .busData(busFreq));

   stage_store #(.N(`SEQ_STAGES), .W(8), .RST(`DIR_RST)) u_dir (
      .mclk(mclk), .sys_rst(sys_rst), .wrEn(wrDir), .wrIdx(wIdx),
      .wrData(wData_q[7:0]), .wrMask(wMask[7:0]), .seqIdx(stage_q),
      .seqData(curDir), .busIdx(s_axi_araddr[4:2]), .busData(busDir));

   // Sequencer
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q      <= ST_IDLE;
         stage_q      <= 3'h0;
         remain_q     <= {TW{1'b0}};
         load_q       <= 1'b0;
         armed_q      <= 1'b0;
         ev_q         <= {`IRQ_W{1'b0}};
         rstActPrev_q <= 1'b0;
         selPrev_q    <= 1'b0;
      end else begin
         ev_q         <= {`IRQ_W{1'b0}};
         rstActPrev_q <= resetCmdTerm;
         selPrev_q    <= freqSrcSelTerm;
         if (protTrip && state_q != ST_TRIP) begin
            state_q         <= ST_TRIP;
            ev_q[`IRQ_TRIP] <= 1'b1;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  if (startEv) begin
                     state_q <= ST_RUN;
                     load_q  <= 1'b1;
                  end
               end
               ST_RUN: begin
                  if (stopEv) begin
                     state_q         <= ST_SUSP;
                     ev_q[`IRQ_SUSP] <= 1'b1;
                  end else if (load_q) begin
                     remain_q <= curTime;
                     load_q   <= 1'b0;
                  end else if (remain_q == {TW{1'b0}}) begin
                     if (stage_q == LAST) begin
                        if (ctrl_q[`CTRL_CYC]) begin
                           stage_q        <= 3'h0;
                           load_q         <= 1'b1;
                           ev_q[`IRQ_ADV] <= 1'b1;
                        end else begin
                           state_q         <= ST_DONE;
                           armed_q         <= 1'b0;
                           ev_q[`IRQ_DONE] <= 1'b1;
                        end
                     end else begin
                        stage_q        <= stage_q + 3'h1;
                        load_q         <= 1'b1;
                        ev_q[`IRQ_ADV] <= 1'b1;
                     end
                  end else if (tick) begin
                     remain_q <= remain_q - 1'b1;
                  end
               end
               ST_SUSP: begin
                  if (rstEv) begin
                     state_q  <= ST_IDLE;
                     stage_q  <= 3'h0;
                     remain_q <= {TW{1'b0}};
                     load_q   <= 1'b0;
                  end else if (startEv) begin
                     state_q <= ST_RUN;
                  end
               end
               ST_TRIP: begin
                  if (rstEv) begin
                     state_q <= ST_SUSP;
                  end
               end
               ST_DONE: begin
                  if (rstEv) begin
                     state_q <= ST_IDLE;
                     stage_q <= 3'h0;
                  end else if (srcTerm) begin
                     if (!termRun) begin
                        armed_q <= 1'b1;
                     end
                     if (armed_q && (wrFreq || selTog)) begin
                        state_q <= ST_RUN;
                        stage_q <= 3'h0;
                        load_q  <= 1'b1;
                     end
                  end else if (startEv) begin
                     state_q <= ST_RUN;
                     stage_q <= 3'h0;
                     load_q  <= 1'b1;
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Drive outputs
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         runCmd_q    <= 1'b0;
         dirRev_q    <= 1'b0;
         rampSet_q   <= 2'h0;
         freqRef_q   <= {FW{1'b0}};
         stageOut_q  <= 3'h0;
         decelStop_q <= 1'b0;
      end else begin
         runCmd_q    <= (state_q == ST_RUN);
         freqRef_q   <= (state_q == ST_RUN) ? curFreq : {FW{1'b0}};
         stageOut_q  <= stage_q;
         decelStop_q <= (state_q == ST_DONE);
         if (state_q == ST_RUN) begin
            dirRev_q <= isRev;
         end
         rampSet_q   <= (state_q == ST_DONE) ? 2'h0 : dirOff[1:0];
      end
   end

   // Register read mux
   always @* begin
      rdMux = 32'h00000000;
      rdOk  = 1'b1;
      case (s_axi_araddr)
         `A_CTRL: rdMux = {29'h0, ctrl_q};
         `A_RSTC: rdMux = {21'h0, rstCode_q};
         `A_STAT: rdMux = {24'h0, runCmd_q, stage_q, 1'b0, state_q};
         `A_INTS: rdMux = {28'h0, intStat_q};
         `A_INTM: rdMux = {28'h0, intMask_q};
         default: begin
            if (s_axi_araddr[1:0] != 2'h0 ||
                s_axi_araddr[4:2] >= `SEQ_STAGES) begin
               rdOk = 1'b0;
            end else if (s_axi_araddr[7:5] == `R_TIME) begin
               rdMux = {{(32-TW){1'b0}}, busTime};
            end else if (s_axi_araddr[7:5] == `R_FREQ) begin
               rdMux = {{(32-FW){1'b0}}, busFreq};
            end else if (s_axi_araddr[7:5] == `R_DIR) begin
               rdMux = {24'h0, busDir};
            end else begin
               rdOk = 1'b0;
            end
         end
      endcase
   end

   // Bus slave
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OK;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `RESP_OK;
         s_axi_rdata   <= 32'h00000000;
         awHeld_q      <= 1'b0;
         wHeld_q       <= 1'b0;
         awAddr_q      <= 8'h00;
         wData_q       <= 32'h00000000;
         wStrb_q       <= 4'h0;
         ctrl_q        <= `CTRL_RST;
         rstCode_q     <= `RSTC_RST;
         intMask_q     <= {`IRQ_W{1'b0}};
         intStat_q     <= {`IRQ_W{1'b0}};
         irq_q         <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_q      <= s_axi_awaddr;
            awHeld_q      <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_q      <= s_axi_wdata;
            wStrb_q      <= s_axi_wstrb;
            wHeld_q      <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wrGo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wrOwn | wrTime | wrFreq | wrDir) ?
                            `RESP_OK : `RESP_ERR;
            if (awAddr_q == `A_CTRL) begin
               ctrl_q <= ctrlW[2:0];
            end
            if (awAddr_q == `A_RSTC) begin
               rstCode_q <= rstcW[10:0];
            end
            if (awAddr_q == `A_INTM) begin
               intMask_q <= intmW[`IRQ_W-1:0];
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (rdGo) begin
            s_axi_rdata   <= rdMux;
            s_axi_rresp   <= rdOk ? `RESP_OK : `RESP_ERR;
            s_axi_rvalid  <= 1'b1;
            s_axi_arready <= 1'b0;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
         // Read clears, a new event in the same cycle wins
         if (rdGo && s_axi_araddr == `A_INTS) begin
            intStat_q <= ev_q;
         end else begin
            intStat_q <= intStat_q | ev_q;
         end
         irq_q <= |(intStat_q & intMask_q);
      end
   end
endmodule // multi_step_speed_sequencer

/* File: rtl/seq_defs.vh */
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH
// Timing and stage count
`define SEQ_CLK_NS      8
`define SEQ_TICK_NS     100000000
`define SEQ_STAGES      7
`define SEQ_LAST        3'h6
// Register byte addresses
`define A_CTRL          8'h00
`define A_RSTC          8'h04
`define A_STAT          8'h08
`define A_INTS          8'h0c
`define A_INTM          8'h10
// Stage table regions, address bits 7:5
`define R_TIME          3'h1
`define R_FREQ          3'h2
`define R_DIR           3'h3
// Control fields
`define CTRL_SRC_LO     0
`define CTRL_CYC        2
`define CTRL_RST        3'h1
`define SRC_TERM        2'h1
`define SRC_KFWD        2'h2
`define SRC_KREV        2'h3
// Reset terminal function codes
`define RSTC_ON         11'h008
`define RSTC_OFF        11'h3f0
`define RSTC_RST        11'h000
// Stage direction codes
`define DIR_FWD1        8'h01
`define DIR_FWD4        8'h04
`define DIR_REV1        8'h0b
`define DIR_REV4        8'h0e
`define DIR_RST         8'h01
`define TIME_RST        16'h0000
`define FREQ_RST        16'h0000
// Interrupt bits
`define IRQ_ADV         0
`define IRQ_DONE        1
`define IRQ_TRIP        2
`define IRQ_SUSP        3
`define IRQ_W           4
// Bus responses
`define RESP_OK         2'h0
`define RESP_ERR        2'h2
`endif

/* File: rtl/tick_divider.v */
`timescale 1ns/1ps
module tick_divider #(
   parameter CYCLES = 12500000
) (
   input  wire mclk,
   input  wire sys_rst,
   input  wire enable,
   output reg  tick_q
);
   reg [31:0] count_q;

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         count_q <= 32'h00000000;
         tick_q  <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (enable) begin
            if (count_q == CYCLES - 1) begin
               count_q <= 32'h00000000;
               tick_q  <= 1'b1;
            end else begin
               count_q <= count_q + 32'h00000001;
            end
         end
      end
   end
endmodule // tick_divider

/* File: rtl/stage_store.v */
`timescale 1ns/1ps
module stage_store #(
   parameter N   = 7,
   parameter W   = 16,
   parameter RST = 0
) (
   input  wire         mclk,
   input  wire         sys_rst,
   input  wire         wrEn,
   input  wire [2:0]   wrIdx,
   input  wire [W-1:0] wrData,
   input  wire [W-1:0] wrMask,
   input  wire [2:0]   seqIdx,
   output wire [W-1:0] seqData,
   input  wire [2:0]   busIdx,
   output wire [W-1:0] busData
);
   reg [W-1:0] mem_q [0:N-1];
   integer     i;

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (i = 0; i < N; i = i + 1) begin
            mem_q[i] <= RST[W-1:0];
         end
      end else if (wrEn && wrIdx < N) begin
         mem_q[wrIdx] <= (mem_q[wrIdx] & ~wrMask) | (wrData & wrMask);
      end
   end

   assign seqData = (seqIdx < N) ? mem_q[seqIdx] : {W{1'b0}};
   assign busData = (busIdx < N) ? mem_q[busIdx] : {W{1'b0}};
endmodule // stage_store

/* File: verif/seq_chk.sv */
`timescale 1ns/1ps
module seq_chk #(
   parameter FW = 16
) (
   input wire logic          mclk,
   input wire logic          sys_rst,
   input wire logic          s_axi_awvalid,
   input wire logic          s_axi_awready,
   input wire logic          s_axi_wvalid,
   input wire logic          s_axi_wready,
   input wire logic          s_axi_bvalid,
   input wire logic          s_axi_arvalid,
   input wire logic          s_axi_arready,
   input wire logic          s_axi_rvalid,
   input wire logic          resetCmdTerm,
   input wire logic          keyReset,
   input wire logic          protTrip,
   input wire logic          runCmd_q,
   input wire logic          dirRev_q,
   input wire logic [1:0]    rampSet_q,
   input wire logic [FW-1:0] freqRef_q,
   input wire logic [2:0]    stageOut_q,
   input wire logic          decelStop_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence tripQuiet;
      protTrip ##1 (!keyReset && $stable(resetCmdTerm))[*5];
   endsequence
   AST_FREQ_IDLE: assert property (
      !runCmd_q |-> freqRef_q == '0)
      else $error("Frequency reference set while stopped");
   AST_STAGE_MAX: assert property (
      stageOut_q != 3'h7)
      else $error("Stage index beyond seventh stage");
   AST_STAGE_STEP: assert property (
      $changed(stageOut_q) |->
      stageOut_q == $past(stageOut_q) + 3'h1 || stageOut_q == 3'h0)
      else $error("Stage moved out of order");
   AST_DONE_RAMP: assert property (
      decelStop_q |-> !runCmd_q && rampSet_q == 2'h0)
      else $error("Cycle end without stop on ramp set one");
   AST_DIR_HOLD: assert property (
      !runCmd_q ##1 !runCmd_q |-> $stable(dirRev_q))
      else $error("Direction changed while stopped");
   AST_TRIP_STOP: assert property (
      protTrip |-> ##[1:3] !runCmd_q)
      else $error("Trip did not stop the run");
   AST_TRIP_HOLD: assert property (
      tripQuiet |-> !runCmd_q)
      else $error("Run resumed after trip without reset");
   AST_B_ANSWER: assert property (
      wrTaken |-> ##[1:2] s_axi_bvalid)
      else $error("Write response late");
   AST_R_ANSWER: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("Read data late");
endmodule // seq_chk

bind multi_step_speed_sequencer seq_chk #(.FW(FW)) u_seq_chk (
   .mclk(mclk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .resetCmdTerm(resetCmdTerm),
   .keyReset(keyReset), .protTrip(protTrip), .runCmd_q(runCmd_q),
   .dirRev_q(dirRev_q), .rampSet_q(rampSet_q), .freqRef_q(freqRef_q),
   .stageOut_q(stageOut_q), .decelStop_q(decelStop_q));

/* File: verif/operator_panel.sv */
`timescale 1ns/1ps
module operator_panel (
   input wire logic mclk,
   output logic     keyFwd,
   output logic     keyRev,
   output logic     keyStop,
   output logic     keyReset,
   output logic     protTrip,
   output logic     forwardRunTerm,
   output logic     reverseRunTerm,
   output logic     resetCmdTerm,
   output logic     freqSrcSelTerm
);
   initial {protTrip, keyReset, keyStop, keyRev, keyFwd} = 5'h00;
   initial {freqSrcSelTerm, resetCmdTerm} = 2'h0;
   initial {reverseRunTerm, forwardRunTerm} = 2'h0;
   // One-cycle key press or trip pulse
   task automatic tap(input int k);
      @(posedge mclk);
      {protTrip, keyReset, keyStop, keyRev, keyFwd} <= 5'h01 << k;
      @(posedge mclk);
      {protTrip, keyReset, keyStop, keyRev, keyFwd} <= 5'h00;
   endtask
   // Terminal levels: select, reset, reverse, forward
   task automatic term(input logic [3:0] v);
      @(posedge mclk);
      {freqSrcSelTerm, resetCmdTerm, reverseRunTerm, forwardRunTerm} <= v;
   endtask
endmodule // operator_panel

/* File: verif/tb_multi_step_speed_sequencer.sv */
`timescale 1ns/1ps
module tb_multi_step_speed_sequencer;
   logic        mclk = 1'h0;
   logic        sysRst = 1'h1;
   logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
   logic [31:0] wData = 32'h0, rdv;
   logic [3:0]  wStrb = 4'hf;
   logic        awValid = 1'h0, wValid = 1'h0, bReady = 1'h0;
   logic        arValid = 1'h0, rReady = 1'h0;
   logic [1:0]  rsp;
   wire  [1:0]  bResp, rResp, rampSet;
   wire  [31:0] rData;
   wire  [15:0] freqRef;
   wire  [2:0]  stage;
   wire         awReady, wReady, bValid, arReady, rValid;
   wire         kF, kR, kS, kX, trip, tF, tR, tX, tS;
   wire         runCmd, dirRev, decelStop, irq;
   int          n_mismatch = 0, num_checks = 0;
   logic [7:0]  dirCode [7] = '{8'h02, 8'h01, 8'h0e, 8'h0d, 8'h02,
                                 8'h04, 8'h02};

   always #4 mclk = ~mclk;

   operator_panel p (.mclk(mclk), .keyFwd(kF), .keyRev(kR), .keyStop(kS),
      .keyReset(kX), .protTrip(trip), .forwardRunTerm(tF),
      .reverseRunTerm(tR), .resetCmdTerm(tX), .freqSrcSelTerm(tS));

   multi_step_speed_sequencer #(.TICK_CYCLES(10)) dut (
      .mclk(mclk), .sys_rst(sysRst), .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .forwardRunTerm(tF), .reverseRunTerm(tR),
      .resetCmdTerm(tX), .freqSrcSelTerm(tS), .keyFwd(kF), .keyRev(kR),
      .keyStop(kS), .keyReset(kX), .protTrip(trip), .runCmd_q(runCmd),
      .dirRev_q(dirRev), .rampSet_q(rampSet), .freqRef_q(freqRef),
      .stageOut_q(stage), .decelStop_q(decelStop), .irq_q(irq));

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
      @(posedge mclk);
      awAddr <= a; wData <= d; wStrb <= s; awValid <= 1'h1; wValid <= 1'h1;
      bReady <= 1'h1;
      do begin
         @(posedge mclk);
         if (awReady) awValid <= 1'h0;
         if (wReady) wValid <= 1'h0;
      end while (bValid !== 1'h1);
      rsp = bResp;
      bReady <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      arAddr <= a; arValid <= 1'h1; rReady <= 1'h1;
      do begin
         @(posedge mclk);
         if (arReady) arValid <= 1'h0;
      end while (rValid !== 1'h1);
      rdv = rData;
      rsp = rResp;
      rReady <= 1'h0;
   endtask

   task automatic waitRun(input logic v);
      for (int t = 0; t < 300 && runCmd !== v; t++) @(posedge mclk);
      chk("run", runCmd, v);
   endtask

   task automatic waitStage(input logic [2:0] s);
      for (int t = 0; t < 600 && !(runCmd === 1'h1 && stage === s); t++)
         @(posedge mclk);
      chk("stage", stage, s);
      repeat (2) @(posedge mclk);
   endtask

   function automatic logic [2:0] expDir(input logic [7:0] c);
      return (c >= 8'h0b) ? {1'h1, 2'(c - 8'h0b)} : {1'h0, 2'(c - 8'h01)};
   endfunction

   task automatic tRegs;
      rd(8'h00); chk("ctrl", rdv, 32'h1);
      rd(8'h04); chk("rstc", rdv, 32'h0);
      rd(8'h14); chk("unmapped", rdv, 32'h0);
      chk("unmapped resp", rsp, 2'h2);
      wr(8'h14, 32'h1); chk("write err", rsp, 2'h2);
      rd(8'h7c); chk("stage seven", {30'h0, rsp}, 32'h2);
      wr(8'h10, 32'hf); chk("write ok", rsp, 2'h0);
      wr(8'h10, 32'h0, 4'h0); rd(8'h10); chk("mask", rdv, 32'hf);
      for (int i = 0; i < 7; i++) begin
         wr(8'(32 + 4 * i), 32'h3);
         wr(8'(64 + 4 * i), 32'(256 + i));
         wr(8'(96 + 4 * i), {24'h0, dirCode[i]});
      end
      rd(8'h64); chk("dir code", rdv, 32'h1);
   endtask

   task automatic tCycle;
      p.term(4'h1);
      for (int i = 0; i < 7; i++) begin
         waitStage(3'(i));
         chk("freq", freqRef, 32'(256 + i));
         chk("running", runCmd, 1'h1);
         chk("dir ramp", {dirRev, rampSet}, expDir(dirCode[i]));
      end
      for (int t = 0; t < 400 && decelStop !== 1'h1; t++) @(posedge mclk);
      repeat (20) @(posedge mclk);
      chk("cycle end", {decelStop, runCmd, rampSet}, 4'h8);
   endtask

   task automatic tRestart;
      p.term(4'h0);
      repeat (3) @(posedge mclk);
      p.term(4'h8);
      waitRun(1'h1);
      chk("restart", stage, 3'h0);
      p.term(4'h9);
   endtask

   task automatic tSuspend;
      waitStage(3'h1);
      p.term(4'h8);
      waitRun(1'h0);
      repeat (30) @(posedge mclk);
      chk("held", {runCmd, stage}, 4'h1);
      p.term(4'ha);
      waitStage(3'h1);
      chk("resume dir", dirRev, 1'h0);
   endtask

   task automatic tTrip;
      waitStage(3'h2);
      p.tap(4);
      waitRun(1'h0);
      repeat (6) @(posedge mclk);
      chk("tripped", {runCmd, stage}, 4'h2);
      p.tap(3);
      waitRun(1'h1);
      chk("after trip", stage, 3'h2);
   endtask

   task automatic tReset;
      p.term(4'h8);
      waitRun(1'h0);
      wr(8'h04, 32'h8);
      p.term(4'hc);
      repeat (4) @(posedge mclk);
      chk("reset on", {runCmd, stage}, 4'h0);
      p.term(4'hd);
      waitStage(3'h1);
      p.term(4'hc);
      waitRun(1'h0);
      wr(8'h04, 32'h3f0);
      p.term(4'h8);
      repeat (4) @(posedge mclk);
      chk("reset off", {runCmd, stage}, 4'h0);
   endtask

   task automatic tKeypad;
      wr(8'h00, 32'h2);
      p.tap(0);
      waitStage(3'h0);
      waitStage(3'h1);
      p.tap(2);
      waitRun(1'h0);
      wr(8'h00, 32'h3);
      p.tap(1);
      waitRun(1'h1);
      chk("keypad resume", stage, 3'h1);
      p.tap(2);
      waitRun(1'h0);
      p.tap(3);
      repeat (4) @(posedge mclk);
      chk("key reset", stage, 3'h0);
      wr(8'h00, 32'h7);
      p.tap(1);
      waitStage(3'h6);
      waitStage(3'h0);
      p.tap(2);
      waitRun(1'h0);
      p.tap(3);
   endtask

   task automatic tIrq;
      chk("irq raised", irq, 1'h1);
      rd(8'h0c); chk("events", rdv, 32'hf);
      repeat (3) @(posedge mclk);
      chk("irq cleared", irq, 1'h0);
      wr(8'h10, 32'h0);
      p.tap(1);
      waitStage(3'h1);
      p.tap(2);
      waitRun(1'h0);
      repeat (3) @(posedge mclk);
      chk("irq masked", irq, 1'h0);
      wr(8'h10, 32'hf);
      repeat (3) @(posedge mclk);
      chk("irq unmasked", irq, 1'h1);
      rd(8'h0c); chk("events", rdv, 32'h9);
      repeat (3) @(posedge mclk);
      chk("irq cleared", irq, 1'h0);
   endtask

   task automatic test_done;
      if (n_mismatch == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge mclk);
      sysRst <= 1'h0;
      tRegs; tCycle; tRestart; tSuspend; tTrip; tReset; tKeypad; tIrq;
      test_done;
   end

   initial begin
      repeat (30000) @(posedge mclk);
      n_mismatch++;
      test_done;
   end
endmodule // tb_multi_step_speed_sequencer
